//--- hdl/ftg_top.sv
// Notes on behaviour
// - window is 0.25 s times two to code
// - upper six window bits read zero
// - pulse counts clear at reset
// - window resets to one second
// - open loop drives level register to converter
// - closed loop uses regulator code instead
// - low supply reset loads every register with its reset value
// - alarms start disabled after reset
// - prescale divider code resets to two
// - reset mode is full speed override
// - count holds pulses seen per window
// - count saturates at 255, overflow status set, alarm output only if enabled
`timescale 1ns/10ps
`default_nettype none
`include "ftg_defs.svh"
module ftg_top
	import ftg_pkg::*;
#(
	parameter int BASE_CYCLES = `FTG_BASE_WINDOW_CYC
)
(
	// clock and reset (reset is the power-on detector)
	input wire logic clk_sys,
	input wire logic rst,
	// register port
	input wire logic reg_wr,
	input wire logic [1:0] reg_idx,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// tachometer pin
	input wire logic speed_pulse_input,
	// mode and regulator
	input wire ftg_mode_t mode_sel,
	input wire logic mode_wr,
	input wire logic [7:0] regulator_code,
	input wire logic [4:0] alarm_en_wdata,
	input wire logic alarm_en_wr,
	// outputs
	output logic [7:0] converter_code,
	output logic [2:0] prescale,
	output logic [4:0] alarm_en,
	output logic overflow_alarm
);
	logic [1:0] window_code;
	logic [7:0] level_code;
	ftg_mode_t mode;
	logic [2:0] speed_pulse_input_sync;
	logic [31:0] base_cnt;
	logic [2:0] quarter_cnt;
	logic base_tick;
	logic [2:0] quarters_needed;
	ftg_cnt_if link();

	// quarter count at the last tick of a code's window (ticks needed less one)
	function automatic logic [2:0] quarters_of(input logic [1:0] code);
		quarters_of = 3'(4'h1 << code) - 3'h1;
	endfunction

	assign quarters_needed = quarters_of(window_code);

	// window code register
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			window_code <= `FTG_WINDOW_RST;
		end else if (reg_wr && reg_idx == `FTG_IDX_WINDOW) begin
			window_code <= reg_wdata[`FTG_WINDOW_MSB:`FTG_WINDOW_LSB];
		end
	end

	// level register
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			level_code <= `FTG_LEVEL_RST;
		end else if (reg_wr && reg_idx == `FTG_IDX_LEVEL) begin
			level_code <= reg_wdata;
		end
	end

	// mode, prescale and alarm enables
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			mode <= FTG_MODE_FULL;
			prescale <= `FTG_PRESCALE_RST;
			alarm_en <= `FTG_ALARM_EN_RST;
		end else begin
			if (mode_wr) begin
				mode <= mode_sel;
			end
			if (alarm_en_wr) begin
				alarm_en <= alarm_en_wdata;
			end
		end
	end

	// converter code selection
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			converter_code <= `FTG_LEVEL_RST;
		end else begin
			unique case (mode)
				FTG_MODE_OPEN: converter_code <= level_code;
				FTG_MODE_CLOSED: converter_code <= regulator_code;
				FTG_MODE_FULL: converter_code <= `FTG_COUNT_MAX;
				default: converter_code <= `FTG_COUNT_MAX;
			endcase
		end
	end

	// pin synchroniser plus edge stage
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			speed_pulse_input_sync <= 3'h0;
		end else begin
			speed_pulse_input_sync <= {speed_pulse_input_sync[1:0], speed_pulse_input};
		end
	end
	assign link.pulse = speed_pulse_input_sync[1] & ~speed_pulse_input_sync[2];

	// quarter-second base timer
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			base_cnt <= 32'h0;
		end else if (base_cnt == 32'(BASE_CYCLES - 1)) begin
			base_cnt <= 32'h0;
		end else begin
			base_cnt <= base_cnt + 32'h1;
		end
	end
	assign base_tick = base_cnt == 32'(BASE_CYCLES - 1);

	// quarters counted inside one window
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			quarter_cnt <= 3'h0;
		end else if (base_tick) begin
			quarter_cnt <= link.window_end ? 3'h0 : quarter_cnt + 3'h1;
		end
	end
	assign link.window_end = base_tick && quarter_cnt >= quarters_needed;

	ftg_pulse_counter u_cnt (
		.clk_sys(clk_sys),
		.rst(rst),
		.link(link)
	);

	// overflow alarm only when enabled
	assign overflow_alarm = link.overflow & alarm_en[2];

	// register read mux
	always_comb begin
		unique case (reg_idx)
			`FTG_IDX_WINDOW: reg_rdata = {6'h00, window_code};
			`FTG_IDX_LEVEL: reg_rdata = level_code;
			`FTG_IDX_COUNT: reg_rdata = link.result;
			`FTG_IDX_STATUS: reg_rdata = {6'h00, mode == FTG_MODE_FULL, link.overflow};
			default: reg_rdata = 8'h00;
		endcase
	end

	win_upper_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
		reg_idx == `FTG_IDX_WINDOW |-> reg_rdata[7:2] == 6'h00)
		else $error("window upper bits nonzero");
	open_level_a: assert property (@(posedge clk_sys) disable iff (rst)
		mode == FTG_MODE_OPEN && $stable(mode) |=> converter_code == $past(level_code))
		else $error("open loop code wrong");
	closed_reg_a: assert property (@(posedge clk_sys) disable iff (rst)
		mode == FTG_MODE_CLOSED |=> converter_code == $past(regulator_code))
		else $error("closed loop code wrong");
	result_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
		!link.window_end |=> $stable(link.result))
		else $error("result moved mid window");
	// a shorter code written mid-window may end the window early, so check the normal end point
	win_len_a: assert property (@(posedge clk_sys) disable iff (rst)
		base_tick && quarter_cnt == quarters_needed |-> link.window_end)
		else $error("window end at wrong time");
	win_restart_a: assert property (@(posedge clk_sys) disable iff (rst)
		link.window_end |=> quarter_cnt == 3'h0)
		else $error("window did not restart");
	win_write_a: assert property (@(posedge clk_sys) disable iff (rst)
		reg_wr && reg_idx == `FTG_IDX_WINDOW |=> window_code == $past(reg_wdata[1:0]))
		else $error("window code not taken");
	level_write_a: assert property (@(posedge clk_sys) disable iff (rst)
		reg_wr && reg_idx == `FTG_IDX_LEVEL |=> level_code == $past(reg_wdata))
		else $error("level code not taken");
	full_code_a: assert property (@(posedge clk_sys) disable iff (rst)
		mode == FTG_MODE_FULL |=> converter_code == `FTG_COUNT_MAX)
		else $error("full mode code wrong");
	prescale_fix_a: assert property (@(posedge clk_sys) disable iff (rst)
		prescale == `FTG_PRESCALE_RST)
		else $error("prescale moved");
	reset_dflt_a: assert property (@(posedge clk_sys)
		$fell(rst) |-> window_code == `FTG_WINDOW_RST && mode == FTG_MODE_FULL
			&& prescale == `FTG_PRESCALE_RST && alarm_en == 5'h00)
		else $error("reset defaults wrong");
	count_rst_a: assert property (@(posedge clk_sys)
		$fell(rst) |-> link.result == 8'h00)
		else $error("count not cleared");
	alarm_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
		!alarm_en[2] |-> !overflow_alarm)
		else $error("alarm while disabled");
	win_cov: cover property (@(posedge clk_sys) disable iff (rst) link.window_end);
	ovf_cov: cover property (@(posedge clk_sys) disable iff (rst) link.overflow);
	open_cov: cover property (@(posedge clk_sys) disable iff (rst) mode == FTG_MODE_OPEN);
	closed_cov: cover property (@(posedge clk_sys) disable iff (rst) mode == FTG_MODE_CLOSED);
	alarm_cov: cover property (@(posedge clk_sys) disable iff (rst) overflow_alarm);
endmodule
`default_nettype wire

//--- hdl/ftg_defs.svh
`ifndef FTG_DEFS_SVH
`define FTG_DEFS_SVH
// register indexes on the simple register port
`define FTG_IDX_WINDOW 2'h0
`define FTG_IDX_LEVEL 2'h1
`define FTG_IDX_COUNT 2'h2
`define FTG_IDX_STATUS 2'h3
// window register field
`define FTG_WINDOW_LSB 0
`define FTG_WINDOW_MSB 1
// reset values
`define FTG_WINDOW_RST 2'h2
`define FTG_LEVEL_RST 8'h00
`define FTG_COUNT_RST 8'h00
`define FTG_PRESCALE_RST 3'h2
`define FTG_ALARM_EN_RST 5'h00
`define FTG_COUNT_MAX 8'hFF
// status bit positions
`define FTG_STAT_OVF 0
`define FTG_STAT_FULL 1
// timing: base window 0.25 s = 250 ms at 125 MHz
`define FTG_BASE_WINDOW_MS 250
`define FTG_CLK_MHZ 125
`define FTG_BASE_WINDOW_CYC (`FTG_BASE_WINDOW_MS * 1000 * `FTG_CLK_MHZ)
`endif

//--- hdl/ftg_pkg.sv
package ftg_pkg;
	typedef enum logic [1:0] {
		FTG_MODE_FULL = 2'h0,
		FTG_MODE_CLOSED = 2'h1,
		FTG_MODE_OPEN = 2'h2
	} ftg_mode_t;
endpackage

//--- hdl/ftg_cnt_if.sv
`timescale 1ns/10ps
`default_nettype none
interface ftg_cnt_if;
	logic pulse;
	logic window_end;
	logic [7:0] result;
	logic overflow;
	modport ctl (output pulse, output window_end, input result, input overflow);
	modport cnt (input pulse, input window_end, output result, output overflow);
endinterface
`default_nettype wire

//--- hdl/ftg_pulse_counter.sv
`timescale 1ns/10ps
`default_nettype none
`include "ftg_defs.svh"
module ftg_pulse_counter
	import ftg_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// counter link
	ftg_cnt_if.cnt link
);
	logic [7:0] run;
	logic run_ovf;

	// running count, saturating at the top value
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			run <= `FTG_COUNT_RST;
			run_ovf <= 1'b0;
		end else if (link.window_end) begin
			run <= link.pulse ? 8'h01 : 8'h00;
			run_ovf <= 1'b0;
		end else if (link.pulse) begin
			if (run == `FTG_COUNT_MAX) begin
				run_ovf <= 1'b1;
			end else begin
				run <= run + 8'h01;
			end
		end
	end

	// result moves only at window end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			link.result <= `FTG_COUNT_RST;
			link.overflow <= 1'b0;
		end else if (link.window_end) begin
			link.result <= run;
			link.overflow <= run_ovf;
		end
	end

	sat_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
		run == `FTG_COUNT_MAX && !link.window_end |=> run == `FTG_COUNT_MAX)
		else $error("count left saturation");
endmodule
`default_nettype wire

//--- verif/ftg_fan_model.sv
`timescale 1ns/10ps
`default_nettype none
module ftg_fan_model (
	// clock
	input wire logic clk_sys,
	// half period in cycles, zero stops the fan
	input wire logic [7:0] half_cyc,
	// tachometer line
	output logic speed_pulse_input
);
	logic [7:0] cnt = 8'h00;
	// square wave moving after falling edges, held low while stopped
	always @(negedge clk_sys) begin
		if (half_cyc == 8'h00) begin
			speed_pulse_input <= 1'b0;
			cnt <= 8'h00;
		end else if (cnt >= half_cyc - 8'h01) begin
			speed_pulse_input <= ~speed_pulse_input;
			cnt <= 8'h00;
		end else begin
			cnt <= cnt + 8'h01;
		end
	end
endmodule
`default_nettype wire

//--- verif/ftg_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module ftg_top_tb;
	import ftg_pkg::*;
	localparam int BASE = 100;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic reg_wr = 1'b0;
	logic [1:0] reg_idx = 2'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic speed_pulse_input;
	ftg_mode_t mode_sel = FTG_MODE_FULL;
	logic mode_wr = 1'b0;
	logic [7:0] regulator_code = 8'h5A;
	logic [4:0] alarm_en_wdata = 5'h04;
	logic alarm_en_wr = 1'b0;
	logic [7:0] converter_code;
	logic [2:0] prescale;
	logic [4:0] alarm_en;
	logic overflow_alarm;
	logic [7:0] half_cyc = 8'h00;
	int n_fail = 0;
	int total_checks = 0;
	// 125 MHz system clock
	always #4 clk_sys = ~clk_sys;
	ftg_top #(.BASE_CYCLES(BASE)) ftg_top_inst (.clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr),
		.reg_idx(reg_idx), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.speed_pulse_input(speed_pulse_input), .mode_sel(mode_sel), .mode_wr(mode_wr),
		.regulator_code(regulator_code), .alarm_en_wdata(alarm_en_wdata), .alarm_en_wr(alarm_en_wr),
		.converter_code(converter_code), .prescale(prescale), .alarm_en(alarm_en),
		.overflow_alarm(overflow_alarm));
	ftg_fan_model ftg_fan_model_inst (.clk_sys(clk_sys), .half_cyc(half_cyc),
		.speed_pulse_input(speed_pulse_input));
	task report_and_stop;
		if (n_fail == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task wr(input logic [1:0] i, input logic [7:0] d);
		@(negedge clk_sys);
		reg_idx = i;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk_sys);
		reg_wr = 1'b0;
	endtask
	// read is combinational, let it settle before comparing
	task rchk(input logic [1:0] i, input logic [7:0] e, input string n);
		@(negedge clk_sys);
		reg_idx = i;
		#1;
		`CHK(n, e, reg_rdata)
	endtask
	task mode(input ftg_mode_t m);
		@(negedge clk_sys);
		mode_sel = m;
		mode_wr = 1'b1;
		@(negedge clk_sys);
		mode_wr = 1'b0;
		cyc(2);
	endtask
	task por;
		rst = 1'b1;
		cyc(20);
		rst = 1'b0;
		cyc(2);
		rchk(2'h0, 8'h02, "window");
		rchk(2'h2, 8'h00, "count");
		rchk(2'h1, 8'h00, "level");
		`CHK("prescale", 3'h2, prescale)
		`CHK("alarm_en", 5'h00, alarm_en)
		`CHK("converter", 8'hFF, converter_code)
	endtask
	// each code counts a 10-cycle pulse train over its window
	task t_window;
		half_cyc = 8'h05;
		wr(2'h0, 8'hFF);
		rchk(2'h0, 8'h03, "window_hi");
		for (int c = 0; c < 4; c++) begin
			wr(2'h0, 8'(c));
			cyc(820 + 2 * (BASE << c));
			rchk(2'h2, 8'(10 << c), "count_code");
		end
		cyc(300);
		rchk(2'h2, 8'h50, "count_hold");
	endtask
	task t_overflow;
		@(negedge clk_sys);
		alarm_en_wr = 1'b1;
		@(negedge clk_sys);
		alarm_en_wr = 1'b0;
		half_cyc = 8'h01;
		cyc(1700);
		rchk(2'h2, 8'hFF, "count_sat");
		rchk(2'h3, 8'h03, "status_ovf");
		`CHK("ovf_alarm", 1'b1, overflow_alarm)
		half_cyc = 8'h00;
		cyc(1700);
		rchk(2'h2, 8'h00, "count_idle");
		`CHK("ovf_clear", 1'b0, overflow_alarm)
	endtask
	// host keeps level codes inside the linear span
	task t_modes;
		mode(FTG_MODE_OPEN);
		wr(2'h1, 8'h08);
		cyc(2);
		`CHK("conv_lo", 8'h08, converter_code)
		wr(2'h1, 8'hB0);
		cyc(2);
		`CHK("conv_hi", 8'hB0, converter_code)
		mode(FTG_MODE_CLOSED);
		wr(2'h1, 8'h40);
		cyc(2);
		`CHK("conv_reg", 8'h5A, converter_code)
		cyc(62500);
		rchk(2'h1, 8'h40, "level_rb");
		mode(FTG_MODE_FULL);
		`CHK("conv_full", 8'hFF, converter_code)
	endtask
	initial begin
		por;
		t_window;
		t_overflow;
		t_modes;
		wr(2'h1, 8'h80);
		por;
		report_and_stop;
	end
	// hang guard
	initial begin
		repeat (100000) @(posedge clk_sys);
		n_fail++;
		report_and_stop;
	end
endmodule
`default_nettype wire
